// ### core/acc_regs.sv
/*
 * Channel configuration and calibration register bank with an AXI4-Lite
 * slave, and the offset and gain correction of the channel's results.
 * Assumes conversion results and the global DC filter setting come from
 * logic on mclk, and that the master keeps one write and one read open.
 */
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "acc_defs.svh"

// Summary of operation
// RULE1: Bits 15:6 of the config register hold a signed phase delay in modulator cycles.
// RULE2: Bits 5:3 of the config register are read-only and read as zero.
// RULE3: Config bit 2 set turns off DC filtering here; clear leaves the global setting.
// RULE4: Config bits 1:0 route the input: pins, shorted, positive or negative test signal.
// RULE5: The offset high register gives bits 23:8 of the signed offset value.
// RULE6: Offset low bits 15:8 give offset bits 7:0; its low byte reads as zero.
// RULE7: The gain high register gives bits 23:8 of the unsigned gain, 0 to under 2.0.
// RULE8: Gain low bits 15:8 give gain bits 7:0; its low byte reads as zero.
// RULE9: Gain high at 16h resets to 8000h for unity gain; gain low at 17h resets to zero.
// RULE10: Offset high and low sit at 14h and 15h and both reset to zero.
// RULE11: The 24-bit offset and gain are assembled and applied to each result.
module acc_regs
    import acc_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int DATA_W = 24
) (
    input  wire logic              mclk,
    input  wire logic              sys_rst,
    input  wire logic              ce,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic [3:0]        global_dc_filter_setting,
    input  wire logic              conv_valid,
    input  wire logic [DATA_W-1:0] conv_data,
    output logic [9:0]             chan_phase_delay,
    output logic                   chan_dc_filter_off,
    output logic [3:0]             chan_dc_filter_code,
    output acc_input_sel_t         chan_input_select,
    output logic                   chan_input_pins_on,
    output logic                   chan_input_shorted,
    output logic                   chan_test_pos_on,
    output logic                   chan_test_neg_on,
    output logic                   corr_valid,
    output logic [DATA_W-1:0]      corr_data
);

    if (ADDR_W < 8 || ADDR_W > 32) begin : g_chk_addr
        $error("acc_regs: ADDR_W must be 8 to 32");
    end
    if (DATA_W != 24) begin : g_chk_data
        $error("acc_regs: DATA_W must be 24");
    end

    // Byte lanes 0 and 1 carry the 16-bit register
    function automatic acc_word_t acc_merge(
        input acc_word_t  old_v,
        input logic [15:0] new_v,
        input logic [1:0]  lanes
    );
        acc_word_t res;
        res = old_v;
        if (lanes[0]) begin
            res[7:0] = new_v[7:0];
        end
        if (lanes[1]) begin
            res[15:8] = new_v[15:8];
        end
        return res;
    endfunction

    // Reset words held as constants so that their fields can be sliced
    localparam acc_word_t RST_CFG     = `ACC_RST_CFG;
    localparam acc_word_t RST_OCAL_LO = `ACC_RST_OCAL_LO;
    localparam acc_word_t RST_GCAL_LO = `ACC_RST_GCAL_LO;

    // Register contents
    logic [9:0]     phase_q;
    logic           dcoff_q;
    acc_input_sel_t sel_q;
    logic [15:0]    ocal_hi_q;
    logic [7:0]     ocal_lo_q;
    logic [15:0]    gcal_hi_q;
    logic [7:0]     gcal_lo_q;

    // Write channel state
    logic              aw_full_q;
    logic              aw_full_d;
    logic              w_full_q;
    logic              w_full_d;
    logic [ADDR_W-1:0] waddr_q;
    logic [15:0]       wdata_q;
    logic [1:0]        wstrb_q;
    logic              awready_q;
    logic              wready_q;
    logic              bvalid_q;
    logic [1:0]        bresp_q;

    // Read channel state
    logic              arready_q;
    logic              rvalid_q;
    logic [31:0]       rdata_q;
    logic [1:0]        rresp_q;

    wire aw_take = s_axi_awvalid & awready_q;
    wire w_take  = s_axi_wvalid & wready_q;
    wire wr_go   = aw_full_q & w_full_q & ~bvalid_q;
    wire b_done  = bvalid_q & s_axi_bready;
    wire ar_take = s_axi_arvalid & arready_q;
    wire r_done  = rvalid_q & s_axi_rready;
    wire rvalid_d = ar_take | (rvalid_q & ~r_done);

    assign aw_full_d = (aw_full_q & ~wr_go) | aw_take;
    assign w_full_d  = (w_full_q & ~wr_go) | w_take;

    // Write decode on the latched address
    wire [4:0] widx   = waddr_q[6:2];
    wire       whigh0 = (waddr_q[ADDR_W-1:7] == '0);
    wire       wr_cfg = wr_go & whigh0 & (widx == `ACC_IDX_CFG);
    wire       wr_ohi = wr_go & whigh0 & (widx == `ACC_IDX_OCAL_HI);
    wire       wr_olo = wr_go & whigh0 & (widx == `ACC_IDX_OCAL_LO);
    wire       wr_ghi = wr_go & whigh0 & (widx == `ACC_IDX_GCAL_HI);
    wire       wr_glo = wr_go & whigh0 & (widx == `ACC_IDX_GCAL_LO);
    wire       wr_hit = wr_cfg | wr_ohi | wr_olo | wr_ghi | wr_glo;

    // Current register images, reserved bits zero
    wire acc_word_t cfg_img = {phase_q, 3'b000, dcoff_q, sel_q}; // [RULE1] [RULE2]
    wire acc_word_t olo_img = {ocal_lo_q, 8'h00}; // [RULE6]
    wire acc_word_t glo_img = {gcal_lo_q, 8'h00}; // [RULE8]

    wire acc_word_t cfg_new = acc_merge(cfg_img, wdata_q, wstrb_q);
    wire acc_word_t ohi_new = acc_merge(ocal_hi_q, wdata_q, wstrb_q);
    wire acc_word_t olo_new = acc_merge(olo_img, wdata_q, wstrb_q);
    wire acc_word_t ghi_new = acc_merge(gcal_hi_q, wdata_q, wstrb_q);
    wire acc_word_t glo_new = acc_merge(glo_img, wdata_q, wstrb_q);

    // Read decode on the request itself
    wire [4:0] ridx   = s_axi_araddr[6:2];
    wire       rhigh0 = (s_axi_araddr[ADDR_W-1:7] == '0);
    wire       rd_cfg = rhigh0 & (ridx == `ACC_IDX_CFG);
    wire       rd_ohi = rhigh0 & (ridx == `ACC_IDX_OCAL_HI);
    wire       rd_olo = rhigh0 & (ridx == `ACC_IDX_OCAL_LO);
    wire       rd_ghi = rhigh0 & (ridx == `ACC_IDX_GCAL_HI);
    wire       rd_glo = rhigh0 & (ridx == `ACC_IDX_GCAL_LO);
    wire       rd_hit = rd_cfg | rd_ohi | rd_olo | rd_ghi | rd_glo;

    wire acc_word_t rd_word =
        rd_cfg ? cfg_img :
        rd_ohi ? ocal_hi_q :
        rd_olo ? olo_img :
        rd_ghi ? gcal_hi_q :
        rd_glo ? glo_img : 16'h0000;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            aw_full_q <= 1'b0;
            w_full_q  <= 1'b0;
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
            waddr_q   <= '0;
            wdata_q   <= 16'h0000;
            wstrb_q   <= 2'b00;
        end else if (ce) begin
            aw_full_q <= aw_full_d;
            w_full_q  <= w_full_d;
            awready_q <= ~aw_full_d;
            wready_q  <= ~w_full_d;
            if (aw_take) begin
                waddr_q <= s_axi_awaddr;
            end
            if (w_take) begin
                wdata_q <= s_axi_wdata[15:0];
                wstrb_q <= s_axi_wstrb[1:0];
            end
        end
    end

    // Response waits for both address and data
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            bvalid_q <= 1'b0;
            bresp_q  <= `ACC_RESP_OKAY;
        end else if (ce) begin
            if (wr_go) begin
                bvalid_q <= 1'b1;
                bresp_q  <= wr_hit ? `ACC_RESP_OKAY : `ACC_RESP_SLVERR;
            end else if (b_done) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            phase_q <= RST_CFG[`ACC_PHASE_MSB:`ACC_PHASE_LSB];
            dcoff_q <= RST_CFG[`ACC_DCOFF_BIT];
            sel_q   <= acc_sel_pins;
        end else if (ce && wr_cfg) begin
            phase_q <= cfg_new[`ACC_PHASE_MSB:`ACC_PHASE_LSB]; // [RULE1]
            dcoff_q <= cfg_new[`ACC_DCOFF_BIT]; // [RULE3]
            sel_q   <= acc_input_sel_t'(cfg_new[`ACC_SEL_MSB:`ACC_SEL_LSB]); // [RULE4]
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ocal_hi_q <= `ACC_RST_OCAL_HI; // [RULE10]
            ocal_lo_q <= RST_OCAL_LO[`ACC_LO_MSB:`ACC_LO_LSB]; // [RULE10]
        end else if (ce) begin
            if (wr_ohi) begin
                ocal_hi_q <= ohi_new; // [RULE5]
            end
            if (wr_olo) begin
                ocal_lo_q <= olo_new[`ACC_LO_MSB:`ACC_LO_LSB]; // [RULE6]
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            gcal_hi_q <= `ACC_RST_GCAL_HI; // [RULE9]
            gcal_lo_q <= RST_GCAL_LO[`ACC_LO_MSB:`ACC_LO_LSB]; // [RULE9]
        end else if (ce) begin
            if (wr_ghi) begin
                gcal_hi_q <= ghi_new; // [RULE7]
            end
            if (wr_glo) begin
                gcal_lo_q <= glo_new[`ACC_LO_MSB:`ACC_LO_LSB]; // [RULE8]
            end
        end
    end

    // Read data is captured at acceptance so it stays stable until taken
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h0000_0000;
            rresp_q   <= `ACC_RESP_OKAY;
        end else if (ce) begin
            arready_q <= ~rvalid_d;
            rvalid_q  <= rvalid_d;
            if (ar_take) begin
                rdata_q <= {16'h0000, rd_word}; // [RULE2]
                rresp_q <= rd_hit ? `ACC_RESP_OKAY : `ACC_RESP_SLVERR;
            end
        end
    end

    // Control outputs, registered once more so that they leave from flops
    logic [9:0]     phase_out_q;
    logic           dcoff_out_q;
    logic [3:0]     dc_code_q;
    acc_input_sel_t sel_out_q;
    logic [3:0]     route_q;

    wire [3:0] route_d = {sel_q == acc_sel_test_neg,
                          sel_q == acc_sel_test_pos,
                          sel_q == acc_sel_shorted,
                          sel_q == acc_sel_pins}; // [RULE4]

    // Cleared bit hands the channel back to the global setting
    wire [3:0] dc_code_d = dcoff_q ? 4'h0 : global_dc_filter_setting; // [RULE3]

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            phase_out_q <= 10'h000;
            dcoff_out_q <= 1'b0;
            dc_code_q   <= 4'h0;
            sel_out_q   <= acc_sel_pins;
            route_q     <= 4'h1;
        end else if (ce) begin
            phase_out_q <= phase_q; // [RULE1]
            dcoff_out_q <= dcoff_q;
            dc_code_q   <= dc_code_d;
            sel_out_q   <= sel_q;
            route_q     <= route_d;
        end
    end

    // Correction: stage one removes the offset, stage two scales by gain
    wire [23:0] offset_val = {ocal_hi_q, ocal_lo_q}; // [RULE11]
    wire [23:0] gain_val   = {gcal_hi_q, gcal_lo_q}; // [RULE11]

    logic              s1_valid_q;
    logic signed [24:0] s1_sum_q;
    logic              out_valid_q;
    logic [23:0]       out_data_q;

    wire signed [24:0] sum_d = $signed({conv_data[23], conv_data})
                             - $signed({offset_val[23], offset_val});

    // Gain is unsigned, so it gets a zero sign bit before the product
    wire signed [49:0] prod   = s1_sum_q * $signed({1'b0, gain_val}); // [RULE7]
    wire signed [26:0] scaled = prod[`ACC_GAIN_SHIFT+26:`ACC_GAIN_SHIFT];
    wire               ovf    = (scaled[26:23] != {4{scaled[23]}});

    // Saturate rather than wrap, a gain near 2.0 can overflow full scale
    wire [23:0] sat_d = !ovf ? scaled[23:0] :
                        scaled[26] ? 24'h80_0000 : 24'h7F_FFFF;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            s1_valid_q  <= 1'b0;
            s1_sum_q    <= 25'sd0;
            out_valid_q <= 1'b0;
            out_data_q  <= 24'h00_0000;
        end else if (ce) begin
            s1_valid_q  <= conv_valid;
            out_valid_q <= s1_valid_q;
            if (conv_valid) begin
                s1_sum_q <= sum_d; // [RULE11]
            end
            if (s1_valid_q) begin
                out_data_q <= sat_d; // [RULE11]
            end
        end
    end

    assign s_axi_awready       = awready_q;
    assign s_axi_wready        = wready_q;
    assign s_axi_bvalid        = bvalid_q;
    assign s_axi_bresp         = bresp_q;
    assign s_axi_arready       = arready_q;
    assign s_axi_rvalid        = rvalid_q;
    assign s_axi_rdata         = rdata_q;
    assign s_axi_rresp         = rresp_q;
    assign chan_phase_delay    = phase_out_q;
    assign chan_dc_filter_off  = dcoff_out_q;
    assign chan_dc_filter_code = dc_code_q;
    assign chan_input_select   = sel_out_q;
    assign chan_input_pins_on  = route_q[0];
    assign chan_input_shorted  = route_q[1];
    assign chan_test_pos_on    = route_q[2];
    assign chan_test_neg_on    = route_q[3];
    assign corr_valid          = out_valid_q;
    assign corr_data           = out_data_q;

endmodule

// ### core/acc_defs.svh
/*
 * Register indices, field positions, reset values and bus codes of the
 * channel calibration and configuration register bank.
 * Assumes it is included by bare name from the design files and the bench.
 */
`ifndef ACC_DEFS_SVH
`define ACC_DEFS_SVH

// Register indices; the byte address is four times the index
`define ACC_IDX_CFG      5'h13
`define ACC_IDX_OCAL_HI  5'h14
`define ACC_IDX_OCAL_LO  5'h15
`define ACC_IDX_GCAL_HI  5'h16
`define ACC_IDX_GCAL_LO  5'h17

// Configuration register fields
`define ACC_PHASE_MSB    15
`define ACC_PHASE_LSB    6
`define ACC_DCOFF_BIT    2
`define ACC_SEL_MSB      1
`define ACC_SEL_LSB      0

// Low calibration registers keep only their upper byte
`define ACC_LO_MSB       15
`define ACC_LO_LSB       8

// Reset values
`define ACC_RST_CFG      16'h0000
`define ACC_RST_OCAL_HI  16'h0000
`define ACC_RST_OCAL_LO  16'h0000
`define ACC_RST_GCAL_HI  16'h8000
`define ACC_RST_GCAL_LO  16'h0000

// Gain of 1.0 is 2^23 in the 24-bit gain value
`define ACC_GAIN_SHIFT   23

// AXI response codes
`define ACC_RESP_OKAY    2'h0
`define ACC_RESP_SLVERR  2'h2

`endif

// ### core/acc_pkg.sv
/*
 * Types of the channel calibration and configuration register bank.
 * Assumes nothing of its surroundings.
 */
package acc_pkg;

    // Modulator input routing
    typedef enum logic [1:0] {
        acc_sel_pins     = 2'b00,
        acc_sel_shorted  = 2'b01,
        acc_sel_test_pos = 2'b10,
        acc_sel_test_neg = 2'b11
    } acc_input_sel_t;

    typedef logic [15:0] acc_word_t;

endpackage

// ### verif/acc_regs_assertions.sv
/*
 * Concurrent checks on the ports of the calibration register bank.
 * Assumes ce stays high in the bench; checks pause while ce is low.
 */
`timescale 1ns/1ps
module acc_regs_chk #(
    parameter int ADDR_W = 8
) (
    input wire logic              mclk,
    input wire logic              sys_rst,
    input wire logic              ce,
    input wire logic              s_axi_awvalid,
    input wire logic              s_axi_awready,
    input wire logic              s_axi_wvalid,
    input wire logic              s_axi_wready,
    input wire logic              s_axi_bvalid,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic [31:0]       s_axi_rdata,
    input wire logic              s_axi_rvalid,
    input wire logic              s_axi_rready,
    input wire logic [3:0]        global_dc_filter_setting,
    input wire logic              conv_valid,
    input wire logic              chan_dc_filter_off,
    input wire logic [3:0]        chan_dc_filter_code,
    input wire logic              corr_valid
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (sys_rst || !ce);

    // Address of the read in flight, to know which reserved bits apply
    logic [ADDR_W-1:0] rd_addr_q;
    always_ff @(posedge mclk) begin
        if (s_axi_arvalid && s_axi_arready) rd_addr_q <= s_axi_araddr;
    end

    chk_cfg_rsv_zero: assert property (s_axi_rvalid && rd_addr_q[6:2] == 5'h13
        |-> s_axi_rdata[5:3] == 3'h0) else $error("config reserved bits read nonzero");
    chk_lo_rsv_zero: assert property (s_axi_rvalid && (rd_addr_q[6:2] == 5'h15
        || rd_addr_q[6:2] == 5'h17) |-> s_axi_rdata[7:0] == 8'h00)
        else $error("low cal reserved byte read nonzero");
    chk_filter_code: assert property (!$past(sys_rst) |-> chan_dc_filter_code ==
        (chan_dc_filter_off ? 4'h0 : $past(global_dc_filter_setting)))
        else $error("channel dc filter code wrong");
    chk_corr_latency: assert property (conv_valid |-> ##2 corr_valid)
        else $error("corrected result missing two cycles after input");
    chk_corr_cause: assert property (corr_valid |-> $past(conv_valid, 2))
        else $error("corrected result without input");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data not returned one cycle after address");
    chk_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped early");
    chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready && !s_axi_bvalid |-> ##2 s_axi_bvalid) else $error("write not answered");
endmodule

bind acc_regs acc_regs_chk #(.ADDR_W(ADDR_W)) u_chk (.mclk, .sys_rst, .ce, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .global_dc_filter_setting,
    .conv_valid, .chan_dc_filter_off, .chan_dc_filter_code, .corr_valid);

// ### verif/acc_regs_bench.sv
/*
 * Self-checking bench of the calibration register bank over AXI4-Lite.
 * Assumes the design's defines header and package are compiled first.
 */
`timescale 1ns/1ps
`include "acc_defs.svh"
module acc_regs_bench;
    localparam logic [7:0] A_CFG = {1'b0, `ACC_IDX_CFG, 2'b00};
    localparam logic [7:0] A_OH  = {1'b0, `ACC_IDX_OCAL_HI, 2'b00};
    localparam logic [7:0] A_OL  = {1'b0, `ACC_IDX_OCAL_LO, 2'b00};
    localparam logic [7:0] A_GH  = {1'b0, `ACC_IDX_GCAL_HI, 2'b00};
    localparam logic [7:0] A_GL  = {1'b0, `ACC_IDX_GCAL_LO, 2'b00};
    logic mclk, sys_rst, ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic s_axi_rready, conv_valid, corr_valid, chan_dc_filter_off, chan_input_pins_on;
    logic chan_input_shorted, chan_test_pos_on, chan_test_neg_on;
    logic [7:0]              s_axi_awaddr, s_axi_araddr;
    logic [31:0]             s_axi_wdata, s_axi_rdata;
    logic [3:0]              s_axi_wstrb, global_dc_filter_setting, chan_dc_filter_code;
    logic [1:0]              s_axi_bresp, s_axi_rresp;
    logic [23:0]             conv_data, corr_data;
    logic [9:0]              chan_phase_delay;
    acc_pkg::acc_input_sel_t chan_input_select;
    int                      errors, cmp_count;
    logic [7:0]              adr[4] = '{A_OH, A_OL, A_GH, A_GL};
    logic [23:0]             xs[4] = '{24'h00_0300, 24'h7f_fff0, 24'h80_0010, 24'hff_ffff};

    acc_regs dut (.mclk, .sys_rst, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .global_dc_filter_setting, .conv_valid,
        .conv_data, .chan_phase_delay, .chan_dc_filter_off, .chan_dc_filter_code,
        .chan_input_select, .chan_input_pins_on, .chan_input_shorted, .chan_test_pos_on,
        .chan_test_neg_on, .corr_valid, .corr_data);

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic hang();
        errors++;
        print_verdict();
    endtask

    // Both channels offered together, each released at its own handshake
    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [3:0] s,
                      input logic [1:0] er);
        int n;
        @(posedge mclk);
        s_axi_awaddr  <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata   <= {16'h0000, d};
        s_axi_wstrb   <= s;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge mclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'b0;
        if (n == 40) hang();
        check({30'h0, s_axi_bresp}, {30'h0, er});
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        @(posedge mclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge mclk);
            if (s_axi_rvalid && s_axi_rready) break;
            // Ready comes a cycle late so read data must stand while unclaimed
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            else if (!s_axi_arvalid) s_axi_rready <= 1'b1;
        end
        s_axi_rready <= 1'b0;
        if (n == 40) hang();
        check(s_axi_rdata, ed);
        check({30'h0, s_axi_rresp}, {30'h0, er});
    endtask

    // Offset first, then gain with 2^23 as unity, floor shift and saturation
    function automatic logic [23:0] exp_corr(input logic [23:0] x, o, g);
        longint p;
        p = ((longint'(signed'(x)) - longint'(signed'(o))) * longint'(g)) >>> 23;
        if (p > 64'sh7f_ffff) return 24'h7f_ffff;
        if (p < -64'sh80_0000) return 24'h80_0000;
        return p[23:0];
    endfunction

    initial begin
        {sys_rst, ce} = 2'b11;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
        {conv_valid, conv_data} = 25'h0;
        global_dc_filter_setting = 4'ha;
        errors = 0;
        cmp_count = 0;
        repeat (3) @(posedge mclk);
        sys_rst <= 1'b0;
        rd(A_CFG, 32'h0000_0000, 2'h0);
        rd(A_OH, 32'h0000_0000, 2'h0);
        rd(A_OL, 32'h0000_0000, 2'h0);
        rd(A_GH, 32'h0000_8000, 2'h0);
        rd(A_GL, 32'h0000_0000, 2'h0);
        check(chan_input_pins_on, 1);
        check(chan_dc_filter_code, 4'ha);
        $display("test reset values done");
        wr(A_CFG, 16'hffff, 4'h3, 2'h0);
        rd(A_CFG, 32'h0000_ffc7, 2'h0);
        check(chan_phase_delay, 10'h3ff);
        check(chan_dc_filter_off, 1);
        check(chan_dc_filter_code, 4'h0);
        for (int i = 0; i < 4; i++) begin
            global_dc_filter_setting <= 4'h5 + 4'(i);
            wr(A_CFG, {10'h201, 4'h0, i[1:0]}, 4'h3, 2'h0);
            #1;
            check(chan_input_select, i[1:0]);
            check({chan_test_neg_on, chan_test_pos_on, chan_input_shorted,
                   chan_input_pins_on}, 4'h1 << i);
            check(chan_phase_delay, 10'h201);
            check(chan_dc_filter_code, 4'h5 + 4'(i));
        end
        $display("test config done");
        for (int i = 0; i < 4; i++) begin
            wr(adr[i], {8'h12 + 8'(i), 8'h5a}, 4'h3, 2'h0);
            rd(adr[i], {16'h0, 8'h12 + 8'(i), i[0] ? 8'h00 : 8'h5a}, 2'h0);
        end
        wr(A_OH, 16'hffff, 4'h1, 2'h0);
        rd(A_OH, 32'h0000_12ff, 2'h0);
        $display("test calibration registers done");
        wr(8'h60, 16'h1111, 4'h3, 2'h2);
        rd(8'h60, 32'h0000_0000, 2'h2);
        rd(8'hd0, 32'h0000_0000, 2'h2);
        rd(A_OH, 32'h0000_12ff, 2'h0);
        $display("test unmapped done");
        wr(A_OH, 16'h0001, 4'h3, 2'h0);
        wr(A_OL, 16'h8000, 4'h3, 2'h0);
        wr(A_GH, 16'hc000, 4'h3, 2'h0);
        wr(A_GL, 16'h8000, 4'h3, 2'h0);
        // Back-to-back inputs; each result is due two drive steps later
        for (int k = 0; k < 8; k++) begin
            @(posedge mclk);
            conv_valid <= (k < 4);
            conv_data  <= xs[k % 4];
            #1;
            check(corr_valid, k >= 2 && k < 6);
            if (k >= 2 && k < 6)
                check(corr_data, exp_corr(xs[k-2], 24'h00_0180, 24'hc0_0080));
        end
        $display("test correction done");
        print_verdict();
    end
endmodule
